// ---- dip_input_pipeline.v ----
// input pipeline, pre-adder and multiplier stage of a multiply-accumulate slice
// Functional notes
// - A input has two optional stages, separate enables, shared synchronous reset.
// - B input has two optional stages, separate enables, shared synchronous reset.
// - optional pre-adder result register, own enable, cleared by the D path reset.
// - optional ALU operation word register with own enable and reset.
// - optional C input register with own enable and reset.
// - optional carry input register, own enable, cleared by all-carry reset.
// - optional carry source select register using the shared control enable and reset.
// - optional D register, own enable, cleared by the D path reset.
// - optional 5-bit input mode register controls pre-adder, sign and A source.
// - internal multiplier carry register uses multiplier enable and reset.
// - optional multiplier register holds two 43-bit partial products.
// - optional operating mode word register using control enable and reset.
// - optional output register captures results and drives the cascade outputs.
// - data ports: A 30, B 18, C 48, D 25 bits.
// - signed 25 by 18 multiplier from low A bits and B path.
// - A:B concatenation bypasses multiplier, A upper 30, B lower 18 bits.
// - cascaded A and B operands arrive on dedicated 30 and 18 bit inputs.
// - direct and cascade paths support zero, one or two stages.
// - mode bit 0 picks first or second A stage; bit 1 zeroes it.
// - with pre-adder, bit 2 adds D and bit 3 negates the A term.
// - mode bit 4 picks the B stage, independent of pre-adder encoding.
// - mode bit 4 zero selects second B stage, one selects first.
`timescale 1ns/10ps
`include "dip_defines.vh"
module dip_input_pipeline (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [`DIP_A_W-1:0] a_in,
  input wire [`DIP_B_W-1:0] b_in,
  input wire [`DIP_C_W-1:0] c_in,
  input wire [`DIP_D_W-1:0] d_in,
  input wire [`DIP_A_W-1:0] a_cascade_in,
  input wire [`DIP_B_W-1:0] b_cascade_in,
  input wire [`DIP_IM_W-1:0] input_mode_word,
  input wire [`DIP_OP_W-1:0] operating_mode_word,
  input wire [`DIP_ALU_W-1:0] alu_op_word,
  input wire carry_input,
  input wire [`DIP_CS_W-1:0] carry_source_select,
  input wire a_first_stage_enable,
  input wire a_second_stage_enable,
  input wire b_first_stage_enable,
  input wire b_second_stage_enable,
  input wire preadd_reg_enable,
  input wire d_input_enable,
  input wire c_reg_enable,
  input wire alu_op_reg_enable,
  input wire carry_in_reg_enable,
  input wire ctrl_reg_enable,
  input wire input_mode_reg_enable,
  input wire mult_reg_enable,
  input wire out_reg_enable,
  input wire a_stage_reset,
  input wire b_stage_reset,
  input wire d_path_reset,
  input wire c_reg_reset,
  input wire alu_op_reg_reset,
  input wire all_carry_in_reset,
  input wire ctrl_reg_reset,
  input wire input_mode_reg_reset,
  input wire mult_reg_reset,
  input wire out_reg_reset,
  output wire [`DIP_A_W-1:0] a_cascade_out,
  output wire [`DIP_B_W-1:0] b_cascade_out,
  output wire [`DIP_C_W-1:0] result,
  output wire carry_out,
  output wire pattern_match_flag,
  output wire [`DIP_C_W-1:0] result_cascade_out,
  output wire carry_cascade_out,
  output wire mult_sign_cascade_out
);

  // picks the stage output for a 0, 1 or 2 deep path
  function [`DIP_A_W-1:0] stage_pick;
    input [1:0] depth;
    input [`DIP_A_W-1:0] thru;
    input [`DIP_A_W-1:0] reg_val;
    begin
      stage_pick = (depth == 2'h0) ? thru : reg_val;
    end
  endfunction

  // configuration word written by software
  reg [`DIP_CFG_W-1:0] cfg_q;
  reg wr_pend_q;
  wire [1:0] a_depth = cfg_q[`DIP_F_A_STAGE_COUNT+1:`DIP_F_A_STAGE_COUNT];
  wire [1:0] b_depth = cfg_q[`DIP_F_B_STAGE_COUNT+1:`DIP_F_B_STAGE_COUNT];
  wire [1:0] a_casc = cfg_q[`DIP_F_ACASC+1:`DIP_F_ACASC];
  wire [1:0] b_casc = cfg_q[`DIP_F_BCASC+1:`DIP_F_BCASC];
  wire [1:0] mult_usage = cfg_q[`DIP_F_MUSE+1:`DIP_F_MUSE];
  wire preadder_use = cfg_q[`DIP_F_PREUSE];

  // pipeline registers
  reg [`DIP_A_W-1:0] a1_q;
  reg [`DIP_A_W-1:0] a2_q;
  reg [`DIP_B_W-1:0] b1_q;
  reg [`DIP_B_W-1:0] b2_q;
  reg [`DIP_D_W-1:0] d_q;
  reg [`DIP_MA_W-1:0] ad_q;
  reg [`DIP_C_W-1:0] c_q;
  reg [`DIP_IM_W-1:0] im_q;
  reg [`DIP_OP_W-1:0] op_q;
  reg [`DIP_ALU_W-1:0] alu_q;
  reg ci_q;
  reg [`DIP_CS_W-1:0] cs_q;
  reg [`DIP_PP_W-1:0] pp0_q;
  reg [`DIP_PP_W-1:0] pp1_q;
  reg mcarry_q;
  reg [`DIP_C_W-1:0] p_q;
  reg co_q;
  reg pat_q;
  reg msign_q;

  // source choice: dedicated cascade inputs versus direct ports
  wire [`DIP_A_W-1:0] a_src = cfg_q[`DIP_F_A_CASCADE_IN] ? a_cascade_in : a_in;
  wire [`DIP_B_W-1:0] b_src = cfg_q[`DIP_F_B_CASCADE_IN] ? b_cascade_in : b_in;

  // depth two feeds the second stage from the first
  wire [`DIP_A_W-1:0] a1_eff = (a_depth == 2'h2) ? a1_q : a_src;
  wire [`DIP_B_W-1:0] b1_eff = (b_depth == 2'h2) ? b1_q : b_src;
  wire [`DIP_A_W-1:0] a2_eff = stage_pick(a_depth, a_src, a2_q);
  wire [`DIP_A_W-1:0] b2_wide = stage_pick(b_depth, {12'h000, b_src}, {12'h000, b2_q});
  wire [`DIP_B_W-1:0] b2_eff = b2_wide[`DIP_B_W-1:0];

  // cascade out taps the chosen stage
  assign a_cascade_out = (a_casc == 2'h0) ? a_src : ((a_casc == 2'h1) ? a2_eff : a1_q);
  assign b_cascade_out = (b_casc == 2'h0) ? b_src : ((b_casc == 2'h1) ? b2_eff : b1_q);

  // registered or flow-through input mode word
  wire [`DIP_IM_W-1:0] im_eff = cfg_q[`DIP_F_IMREG] ? im_q : input_mode_word;
  wire [`DIP_D_W-1:0] d_eff = cfg_q[`DIP_F_D_REG_SELECT] ? d_q : d_in;
  wire [`DIP_C_W-1:0] c_eff = cfg_q[`DIP_F_C_REG_SELECT] ? c_q : c_in;
  wire [`DIP_OP_W-1:0] op_eff = cfg_q[`DIP_F_OPREG] ? op_q : operating_mode_word;
  wire [`DIP_ALU_W-1:0] alu_eff = cfg_q[`DIP_F_ALUREG] ? alu_q : alu_op_word;
  wire ci_eff = cfg_q[`DIP_F_CIREG] ? ci_q : carry_input;
  wire [`DIP_CS_W-1:0] cs_eff = cfg_q[`DIP_F_CSREG] ? cs_q : carry_source_select;

  // A operand stage select and zero force
  wire [`DIP_A_W-1:0] a_sel = im_eff[0] ? a1_eff : a2_eff;
  wire [`DIP_MA_W-1:0] a_term = im_eff[1] ? {`DIP_MA_W{1'b0}} : a_sel[`DIP_MA_W-1:0];
  // pre-adder bits only act when the pre-adder is in use
  wire d_add = preadder_use & im_eff[2];
  wire a_neg = preadder_use & im_eff[3];
  wire [`DIP_D_W-1:0] d_term = d_add ? d_eff : {`DIP_D_W{1'b0}};
  wire [`DIP_MA_W-1:0] ad_sum = a_neg ? (d_term - a_term) : (d_term + a_term);
  wire [`DIP_MA_W-1:0] mult_a = cfg_q[`DIP_F_PREADD_REG_SELECT] ? ad_q : ad_sum;
  // mode bit 4 alone picks the B stage
  wire [`DIP_B_W-1:0] mult_b = im_eff[4] ? b1_eff : b2_eff;

  wire signed [`DIP_PP_W-1:0] prod = $signed(mult_a) * $signed(mult_b);
  // power saving when the multiplier is declared unused
  wire [`DIP_PP_W-1:0] prod_g = (mult_usage == `DIP_MUSE_NONE) ? {`DIP_PP_W{1'b0}} : prod;
  // second partial product kept zero so the X plus Y sum is the product
  wire [`DIP_PP_W-1:0] pp1_d = {`DIP_PP_W{1'b0}};
  wire [`DIP_PP_W-1:0] pp0_eff = cfg_q[`DIP_F_MULT_REG_SELECT] ? pp0_q : prod_g;
  wire [`DIP_PP_W-1:0] pp1_eff = cfg_q[`DIP_F_MULT_REG_SELECT] ? pp1_q : pp1_d;
  wire msign_eff = cfg_q[`DIP_F_MULT_REG_SELECT] ? mcarry_q : prod_g[`DIP_PP_W-1];

  // A:B bypass only when multiplier is none or dynamic
  wire ab_ok = (mult_usage == `DIP_MUSE_NONE) | (mult_usage == `DIP_MUSE_DYN);
  wire [`DIP_C_W-1:0] ab_cat = {a2_eff, b2_eff};
  wire [`DIP_C_W-1:0] x_val = (op_eff[1:0] == `DIP_XSEL_AB && ab_ok) ? ab_cat :
                              ((op_eff[1:0] == `DIP_XSEL_M) ? {{5{pp0_eff[`DIP_PP_W-1]}}, pp0_eff} : 48'h000000000000);
  wire [`DIP_C_W-1:0] y_val = (op_eff[3:2] == `DIP_YSEL_M) ? {{5{pp1_eff[`DIP_PP_W-1]}}, pp1_eff} :
                              ((op_eff[3:2] == `DIP_YSEL_C) ? c_eff : 48'h000000000000);
  wire [`DIP_C_W:0] xy_sum = {1'b0, x_val} + {1'b0, y_val};
  wire pat_d = (xy_sum[`DIP_C_W-1:0] == c_eff);

  // A stages, own enables, shared reset
  always @(posedge clk) begin
    if (!rst_n || a_stage_reset) begin
      a1_q <= 30'h00000000;
      a2_q <= 30'h00000000;
    end else begin
      if (a_first_stage_enable)
        a1_q <= a_src;
      if (a_second_stage_enable)
        a2_q <= a1_eff;
    end
  end

  // B stages, own enables, shared reset
  always @(posedge clk) begin
    if (!rst_n || b_stage_reset) begin
      b1_q <= 18'h00000;
      b2_q <= 18'h00000;
    end else begin
      if (b_first_stage_enable)
        b1_q <= b_src;
      if (b_second_stage_enable)
        b2_q <= b1_eff;
    end
  end

  // D register and pre-adder register share one reset
  always @(posedge clk) begin
    if (!rst_n || d_path_reset) begin
      d_q <= 25'h0000000;
      ad_q <= 25'h0000000;
    end else begin
      if (d_input_enable)
        d_q <= d_in;
      if (preadd_reg_enable)
        ad_q <= ad_sum;
    end
  end

  always @(posedge clk) begin
    if (!rst_n || c_reg_reset)
      c_q <= 48'h000000000000;
    else if (c_reg_enable)
      c_q <= c_in;
  end

  always @(posedge clk) begin
    if (!rst_n || input_mode_reg_reset)
      im_q <= 5'h00;
    else if (input_mode_reg_enable)
      im_q <= input_mode_word;
  end

  always @(posedge clk) begin
    if (!rst_n || alu_op_reg_reset)
      alu_q <= 4'h0;
    else if (alu_op_reg_enable)
      alu_q <= alu_op_word;
  end

  always @(posedge clk) begin
    if (!rst_n || all_carry_in_reset)
      ci_q <= 1'b0;
    else if (carry_in_reg_enable)
      ci_q <= carry_input;
  end

  // carry select and operating mode share control enable and reset
  always @(posedge clk) begin
    if (!rst_n || ctrl_reg_reset) begin
      cs_q <= 3'h0;
      op_q <= 7'h00;
    end else if (ctrl_reg_enable) begin
      cs_q <= carry_source_select;
      op_q <= operating_mode_word;
    end
  end

  // partial product register and internal carry register
  always @(posedge clk) begin
    if (!rst_n || mult_reg_reset) begin
      pp0_q <= 43'h00000000000;
      pp1_q <= 43'h00000000000;
      mcarry_q <= 1'b0;
    end else if (mult_reg_enable) begin
      pp0_q <= prod_g;
      pp1_q <= pp1_d;
      mcarry_q <= prod_g[`DIP_PP_W-1];
    end
  end

  // output register also feeds the cascade outputs
  always @(posedge clk) begin
    if (!rst_n || out_reg_reset) begin
      p_q <= 48'h000000000000;
      co_q <= 1'b0;
      pat_q <= 1'b0;
      msign_q <= 1'b0;
    end else if (out_reg_enable) begin
      p_q <= xy_sum[`DIP_C_W-1:0];
      co_q <= xy_sum[`DIP_C_W];
      pat_q <= pat_d;
      msign_q <= msign_eff;
    end
  end

  // flow-through when the output register is configured out
  assign result = cfg_q[`DIP_F_OUT_REG_SELECT] ? p_q : xy_sum[`DIP_C_W-1:0];
  assign carry_out = cfg_q[`DIP_F_OUT_REG_SELECT] ? co_q : xy_sum[`DIP_C_W];
  assign pattern_match_flag = cfg_q[`DIP_F_OUT_REG_SELECT] ? pat_q : pat_d;
  assign result_cascade_out = result;
  assign carry_cascade_out = carry_out;
  assign mult_sign_cascade_out = cfg_q[`DIP_F_OUT_REG_SELECT] ? msign_q : msign_eff;

  // bus slave: zero wait states, read data prepared in the address phase
  wire addr_ok = hsel && hready && htrans == `DIP_HTRANS_NONSEQ;
  wire [31:0] stat_word = {12'h000, ci_eff, cs_eff, alu_eff, op_eff, im_eff};
  reg [11:0] wr_addr_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= 23'h000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[11:0];
      // write data arrives one cycle after its address
      if (wr_pend_q && wr_addr_q == `DIP_ADDR_CFG)
        cfg_q <= hwdata[`DIP_CFG_W-1:0];
      if (addr_ok && !hwrite) begin
        if (haddr[11:0] == `DIP_ADDR_CFG)
          hrdata <= {9'h000, cfg_q};
        else if (haddr[11:0] == `DIP_ADDR_STAT)
          hrdata <= stat_word;
        else
          hrdata <= 32'h00000000;
      end
    end
  end

endmodule

// ---- dip_defines.vh ----
// constants for the slice input pipeline and pre-adder
`ifndef DIP_DEFINES_VH
`define DIP_DEFINES_VH
`define DIP_A_W 30
`define DIP_B_W 18
`define DIP_C_W 48
`define DIP_D_W 25
`define DIP_MA_W 25
`define DIP_PP_W 43
`define DIP_IM_W 5
`define DIP_OP_W 7
`define DIP_ALU_W 4
`define DIP_CS_W 3
`define DIP_ADDR_CFG 12'h000
`define DIP_ADDR_STAT 12'h004
`define DIP_CFG_RESET 32'h00000000
`define DIP_CFG_W 23
`define DIP_F_A_STAGE_COUNT 0
`define DIP_F_B_STAGE_COUNT 2
`define DIP_F_ACASC 4
`define DIP_F_BCASC 6
`define DIP_F_PREADD_REG_SELECT 8
`define DIP_F_ALUREG 9
`define DIP_F_C_REG_SELECT 10
`define DIP_F_CIREG 11
`define DIP_F_CSREG 12
`define DIP_F_D_REG_SELECT 13
`define DIP_F_IMREG 14
`define DIP_F_MULT_REG_SELECT 15
`define DIP_F_OPREG 16
`define DIP_F_OUT_REG_SELECT 17
`define DIP_F_PREUSE 18
`define DIP_F_MUSE 19
`define DIP_F_A_CASCADE_IN 21
`define DIP_F_B_CASCADE_IN 22
`define DIP_MUSE_NONE 2'h0
`define DIP_MUSE_MULT 2'h1
`define DIP_MUSE_DYN 2'h2
`define DIP_XSEL_M 2'h1
`define DIP_XSEL_AB 2'h3
`define DIP_YSEL_M 2'h1
`define DIP_YSEL_C 2'h3
`define DIP_HTRANS_NONSEQ 2'h2
`endif

// ---- dip_chk.sv ----
// bus-snooping checker for the slice input pipeline
`timescale 1ns/10ps
`include "dip_defines.vh"
module dip_chk (
  input logic clk,
  input logic rst_n,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic [`DIP_A_W-1:0] a_in,
  input logic [`DIP_B_W-1:0] b_in,
  input logic [`DIP_C_W-1:0] c_in,
  input logic [`DIP_OP_W-1:0] operating_mode_word,
  input logic a_first_stage_enable,
  input logic a_second_stage_enable,
  input logic a_stage_reset,
  input logic c_reg_enable,
  input logic c_reg_reset,
  input logic out_reg_enable,
  input logic out_reg_reset,
  input logic [`DIP_A_W-1:0] a_cascade_out,
  input logic [`DIP_B_W-1:0] b_cascade_out,
  input logic [`DIP_C_W-1:0] result
);
  logic wr_q;
  logic [`DIP_CFG_W-1:0] cfg_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow of the config word, rebuilt from bus writes since it has no port of its own
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= 1'h0;
      cfg_q <= 23'h0;
    end else if (hreadyout) begin
      wr_q <= hsel && htrans == `DIP_HTRANS_NONSEQ && hwrite && haddr == 32'h0;
      if (wr_q) begin
        cfg_q <= hwdata[`DIP_CFG_W-1:0];
      end
    end
  end
  sequence rd_req;
    hsel && hreadyout && htrans == `DIP_HTRANS_NONSEQ && !hwrite && haddr == 32'h0;
  endsequence
  sequence a_pipe;
    cfg_q == 23'h2 && a_first_stage_enable && a_second_stage_enable && !a_stage_reset;
  endsequence
  sequence c_load;
    cfg_q == 23'h20400 && operating_mode_word == 7'h0C && c_reg_enable && !c_reg_reset;
  endsequence
  sequence p_load;
    cfg_q == 23'h20400 && operating_mode_word == 7'h0C && out_reg_enable && !out_reg_reset;
  endsequence
  chk_cfg_read: assert property (rd_req |=> hrdata == {9'h0, cfg_q})
    else $error("config read back differs");
  chk_bypass_c: assert property (cfg_q[17:0] == 18'h0 && operating_mode_word == 7'h0C |-> result == c_in)
    else $error("bypassed C path not direct");
  chk_ab_concat: assert property (cfg_q[17:0] == 18'h0 && cfg_q[22:19] == 4'h0 && operating_mode_word == 7'h03
    |-> result == {a_in, b_in})
    else $error("A:B concatenation wrong");
  chk_out_reset: assert property (cfg_q[17] && out_reg_reset |=> result == 48'h0)
    else $error("output register not cleared");
  chk_c_reg: assert property (c_load ##1 p_load |=> result == $past(c_in, 2))
    else $error("C register latency wrong");
  chk_a_depth: assert property (a_pipe ##1 a_pipe |=> cfg_q != 23'h2 || operating_mode_word != 7'h03
    || result[47:18] == $past(a_in, 2))
    else $error("A two-stage delay wrong");
  chk_a_tap: assert property (cfg_q[5:4] == 2'h0 && !cfg_q[21] |-> a_cascade_out == a_in)
    else $error("A cascade tap wrong");
  chk_b_tap: assert property (cfg_q[7:6] == 2'h0 && !cfg_q[22] |-> b_cascade_out == b_in)
    else $error("B cascade tap wrong");
endmodule

// ---- dip_fabric.sv ----
// fabric-side model that feeds operands into the slice
`timescale 1ns/10ps
`include "dip_defines.vh"
module dip_fabric (
  output logic [`DIP_A_W-1:0] a_in,
  output logic [`DIP_B_W-1:0] b_in,
  output logic [`DIP_C_W-1:0] c_in,
  output logic [`DIP_D_W-1:0] d_in,
  output logic [`DIP_A_W-1:0] a_cascade_in,
  output logic [`DIP_B_W-1:0] b_cascade_in
);
  // known operands from time zero so nothing undriven reaches the slice
  initial begin
    {a_in, b_in, c_in, d_in, a_cascade_in, b_cascade_in} = 169'h0;
  end
  // callers keep pre-adder operands small, the sum never wraps
  task put(input logic [29:0] a, input logic [17:0] b, input logic [47:0] c, input logic [24:0] d,
    input logic [29:0] ac, input logic [17:0] bc);
    {a_in, b_in, c_in, d_in, a_cascade_in, b_cascade_in} <= {a, b, c, d, ac, bc};
  endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the slice input pipeline
`timescale 1ns/10ps
`include "dip_defines.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; $display("BAD %0t %h %h", $time, a, e); end end
module tb;
  logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, carry_input = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, carry_source_select = 3'h0;
  logic [4:0] input_mode_word = 5'h0;
  logic [6:0] operating_mode_word = 7'h0;
  logic [3:0] alu_op_word = 4'h0;
  logic a_first_stage_enable = 1'h1, a_second_stage_enable = 1'h1, b_first_stage_enable = 1'h1;
  logic b_second_stage_enable = 1'h1, preadd_reg_enable = 1'h1, d_input_enable = 1'h1, c_reg_enable = 1'h1;
  logic alu_op_reg_enable = 1'h1, carry_in_reg_enable = 1'h1, ctrl_reg_enable = 1'h1;
  logic input_mode_reg_enable = 1'h1, mult_reg_enable = 1'h1, out_reg_enable = 1'h1;
  logic a_stage_reset = 1'h0, b_stage_reset = 1'h0, d_path_reset = 1'h0, c_reg_reset = 1'h0;
  logic alu_op_reg_reset = 1'h0, all_carry_in_reset = 1'h0, ctrl_reg_reset = 1'h0;
  logic input_mode_reg_reset = 1'h0, mult_reg_reset = 1'h0, out_reg_reset = 1'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, carry_out, pattern_match_flag, carry_cascade_out, mult_sign_cascade_out;
  wire [29:0] a_in, a_cascade_in, a_cascade_out;
  wire [17:0] b_in, b_cascade_in, b_cascade_out;
  wire [47:0] c_in, result, result_cascade_out;
  wire [24:0] d_in;
  logic signed [24:0] op;
  logic signed [47:0] ex;
  int err_count = 0, comparisons = 0, cycles = 0;
  dip_input_pipeline uut (.*, .hready(hreadyout));
  dip_fabric fab (.*);
  always #5 clk = ~clk;
  // hang guard: the whole run needs about 120 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      conclude();
    end
  end
  // single AHB-Lite transfer, waits on the slave's ready with no assumed latency
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    {hsel, haddr, htrans, hwrite} <= {1'h1, a, `DIP_HTRANS_NONSEQ, w};
    do @(posedge clk); while (hreadyout !== 1'h1);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task conclude;
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    bus(1'h0, 32'h0, 32'h0);
    `CHK(rd, `DIP_CFG_RESET)
    `CHK(hresp, 1'h0)
    // control words flow through to the status word while their registers are off
    {alu_op_word, carry_source_select, carry_input} <= {4'hA, 3'h5, 1'h1};
    bus(1'h0, 32'h4, 32'h0);
    `CHK(rd, 32'h000DA000)
    bus(1'h1, 32'h10, 32'hFFFFFFFF);
    bus(1'h0, 32'h10, 32'h0);
    `CHK(rd, 32'h0)
    operating_mode_word <= 7'h03;
    fab.put(30'h2AAAAAAA, 18'h15555, 48'h123456789ABC, 25'h0, 30'h1234567, 18'h2BCDE);
    @(posedge clk) #1 `CHK(result, {30'h2AAAAAAA, 18'h15555})
    @(posedge clk) operating_mode_word <= 7'h0C;
    @(posedge clk) #1 `CHK(result, 48'h123456789ABC)
    `CHK(pattern_match_flag, 1'h1)
    `CHK(result_cascade_out, 48'h123456789ABC)
    // A:B all ones plus C of one wraps to zero with a carry out
    operating_mode_word <= 7'h0F;
    fab.put(30'h3FFFFFFF, 18'h3FFFF, 48'h1, 25'h0, 30'h1234567, 18'h2BCDE);
    @(posedge clk) #1 `CHK(carry_cascade_out, 1'h1)
    `CHK(result_cascade_out, 48'h0)
    `CHK(pattern_match_flag, 1'h0)
    operating_mode_word <= 7'h03;
    bus(1'h1, 32'h0, 32'h00600000);
    #1 `CHK(result, {30'h1234567, 18'h2BCDE})
    // two A stages: value appears after exactly two loads
    bus(1'h1, 32'h0, 32'h2);
    fab.put(30'h0ABCDEF, 18'h1, 48'h0, 25'h0, 30'h0, 18'h0);
    @(posedge clk) fab.put(30'h3000001, 18'h1, 48'h0, 25'h0, 30'h0, 18'h0);
    @(posedge clk) #1 `CHK(result[47:18], 30'h0ABCDEF)
    `CHK(a_cascade_out, 30'h3000001)
    @(posedge clk) a_stage_reset <= 1'h1;
    @(posedge clk) #1 `CHK(result[47:18], 30'h0)
    @(posedge clk) a_stage_reset <= 1'h0;
    // C register then output register: two cycles, hold and clear
    bus(1'h1, 32'h0, 32'h00020400);
    operating_mode_word <= 7'h0C;
    fab.put(30'h0, 18'h0, 48'h123456789ABC, 25'h0, 30'h0, 18'h0);
    @(posedge clk) #1 `CHK(result, 48'h0)
    @(posedge clk) #1 `CHK(result, 48'h123456789ABC)
    @(posedge clk) c_reg_enable <= 1'h0;
    fab.put(30'h0, 18'h0, 48'hFEDCBA987654, 25'h0, 30'h0, 18'h0);
    repeat (2) @(posedge clk);
    #1 `CHK(result, 48'h123456789ABC)
    @(posedge clk) {out_reg_reset, c_reg_reset} <= 2'h3;
    @(posedge clk) #1 `CHK(result, 48'h0)
    @(posedge clk) {out_reg_reset, c_reg_reset} <= 2'h0;
    @(posedge clk) #1 `CHK(result, 48'h0)
    // every pre-adder code, with and without pre-adder use
    operating_mode_word <= 7'h05;
    fab.put(30'h3FFFFFF9, 18'h3FFFD, 48'h0, 25'h3, 30'h0, 18'h0);
    for (int k = 0; k < 16; k++) begin
      bus(1'h1, 32'h0, {12'h0, 1'h1, k[3], 18'h0});
      input_mode_word <= {1'h0, k[2:0], 1'h0};
      op = (k[3] && k[1]) ? 25'sh3 : 25'sh0;
      if (!k[0]) op = (k[3] && k[2]) ? op + 25'sh7 : op - 25'sh7;
      ex = op * 18'sh3FFFD;
      #1 `CHK(result, ex)
      `CHK(mult_sign_cascade_out, ex[47])
    end
    // first or second A and B stage chosen by the mode word
    bus(1'h1, 32'h0, 32'h0008000A);
    fab.put(30'h5, 18'h3, 48'h0, 25'h0, 30'h0, 18'h0);
    @(posedge clk) fab.put(30'h3FFFFFFE, 18'h7, 48'h0, 25'h0, 30'h0, 18'h0);
    @(posedge clk) {a_first_stage_enable, a_second_stage_enable} <= 2'h0;
    {b_first_stage_enable, b_second_stage_enable} <= 2'h0;
    for (int k = 0; k < 4; k++) begin
      input_mode_word <= {k[1], 3'h0, k[0]};
      ex = (k[0] ? -48'sh2 : 48'sh5) * (k[1] ? 48'sh7 : 48'sh3);
      @(posedge clk) #1 `CHK(result, ex)
    end
    @(posedge clk) a_stage_reset <= 1'h1;
    @(posedge clk) #1 `CHK(result, 48'h0)
    conclude();
  end
endmodule
bind dip_input_pipeline dip_chk chk (.*);
